// [nmc_pkg.sv]
// shared constants and types of the normal-mode command handler
package nmc_pkg;

  // ----------------------------------------------------------------
  // characters
  // ----------------------------------------------------------------
  localparam logic [7:0]  NMC_CHAR_CR   = 8'h0D;
  localparam logic [7:0]  NMC_CHAR_SP   = 8'h20;
  localparam logic [7:0]  NMC_CHAR_EXIT = 8'h78;
  localparam logic [7:0]  NMC_CHAR_PART = 8'h4E;
  localparam logic [7:0]  NMC_CHAR_SER  = 8'h49;
  localparam logic [7:0]  NMC_CHAR_CONF = 8'h43;
  localparam logic [7:0]  NMC_CHAR_TRIM = 8'h54;
  localparam logic [7:0]  NMC_CHAR_ERR  = 8'h45;
  localparam logic [7:0]  NMC_CHAR_RST  = 8'h52;
  localparam logic [7:0]  NMC_CHAR_DIG0 = 8'h30;
  localparam logic [7:0]  NMC_CHAR_DIG9 = 8'h39;

  // ----------------------------------------------------------------
  // maintenance entry keyword, first character in the top byte
  // ----------------------------------------------------------------
  localparam logic [87:0] NMC_KW_TEXT   = 88'h53_45_52_56_49_43_45_4D_4F_44_45;
  localparam logic [3:0]  NMC_KW_LEN    = 4'hB;
  localparam logic [3:0]  NMC_LEN_SAT   = 4'hF;
  localparam logic [9:0]  NMC_ID_MAX    = 10'h0FF;
  localparam logic [1:0]  NMC_ID_DIGITS = 2'h3;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int          NMC_FIFO_DEPTH = 8;
  localparam int          NMC_KIND_W     = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    NMC_K_PART, NMC_K_SERIAL, NMC_K_CONFIG, NMC_K_TRIM, NMC_K_ERR
  } nmc_kind_e;

  typedef enum logic [2:0] {
    NMC_OP_NONE, NMC_OP_SPECIAL, NMC_OP_RESET, NMC_OP_ENTER, NMC_OP_ENTER_ID, NMC_OP_EXIT
  } nmc_op_e;

  typedef enum logic [2:0] {
    NMC_MD_NORMAL, NMC_MD_FINISH, NMC_MD_DELAY, NMC_MD_MAINT, NMC_MD_MUTED
  } nmc_mode_e;

  typedef struct packed {
    logic      valid;
    nmc_op_e   op;
    nmc_kind_e kind;
    logic [7:0] id;
  } nmc_cmd_s;

endpackage

// [nmc_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module nmc_fifo
  import nmc_pkg::*;
#(
  parameter int WIDTH = NMC_KIND_W,
  parameter int DEPTH = NMC_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
    logic                        not_full;
  } nmc_fifo_s;

  nmc_fifo_s r_reg;
  nmc_fifo_s r_next;
  logic      push;
  logic      pop;

  assign push      = in_valid && r_reg.not_full;
  assign pop       = out_ready && (r_reg.cnt != '0);
  assign in_ready  = r_reg.not_full;
  assign out_valid = (r_reg.cnt != '0);
  assign out_data  = r_reg.mem[r_reg.rd];

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr] = in_data;
      r_next.wr = AW'(r_reg.wr + 1'b1);
    end
    if (pop) begin
      r_next.rd = AW'(r_reg.rd + 1'b1);
    end
    r_next.cnt = (AW+1)'(r_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    // one slot of headroom: a writer one cycle behind its ready cannot overrun
    r_next.not_full = (r_next.cnt < (AW+1)'(DEPTH - 1));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{mem: '0, rd: '0, wr: '0, cnt: '0, not_full: 1'b1};
    end else begin
      r_reg <= r_next;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk) disable iff (rst)
    in_valid |-> r_reg.cnt != (AW+1)'(DEPTH))
    else $error("fifo written while full");
endmodule
`default_nettype wire

// [nmc_parser.sv]
// line parser: turns received characters into one command pulse per carriage return
`timescale 1ns/10ps
`default_nettype none
module nmc_parser
  import nmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output nmc_cmd_s        cmd
);
  typedef struct packed {
    logic [3:0] len;
    logic [7:0] first;
    logic       kw_ok;
    logic       sp_seen;
    logic [1:0] digits;
    logic       id_bad;
    logic [9:0] id;
    nmc_cmd_s   cmd;
  } nmc_parse_s;

  localparam nmc_parse_s IDLE = '{len: '0, first: '0, kw_ok: 1'b1, sp_seen: 1'b0,
                                  digits: '0, id_bad: 1'b0, id: '0, cmd: '0};

  nmc_parse_s r_reg;
  nmc_parse_s r_next;
  logic [7:0] kw_char;
  logic       is_digit;

  assign cmd      = r_reg.cmd;
  assign kw_char  = (r_reg.len < NMC_KW_LEN) ? NMC_KW_TEXT[8*(10-int'(r_reg.len)) +: 8] : 8'h00;
  assign is_digit = (in_data >= NMC_CHAR_DIG0) && (in_data <= NMC_CHAR_DIG9);

  always_comb begin
    r_next = r_reg;
    r_next.cmd = '0;
    if (in_valid) begin
      if (in_data == NMC_CHAR_CR) begin // RULE17
        // nothing is acted on before the terminator; malformed lines vanish silently
        r_next = IDLE; // RULE20
        r_next.cmd.valid = 1'b1;
        r_next.cmd.op = NMC_OP_NONE;
        if (r_reg.first == NMC_CHAR_EXIT) begin
          r_next.cmd.op = NMC_OP_EXIT;
        end else if (r_reg.len == 4'h1) begin
          r_next.cmd.op = NMC_OP_SPECIAL; // RULE1
          case (r_reg.first)
            NMC_CHAR_PART: r_next.cmd.kind = NMC_K_PART;
            NMC_CHAR_SER:  r_next.cmd.kind = NMC_K_SERIAL;
            NMC_CHAR_CONF: r_next.cmd.kind = NMC_K_CONFIG;
            NMC_CHAR_TRIM: r_next.cmd.kind = NMC_K_TRIM;
            NMC_CHAR_ERR:  r_next.cmd.kind = NMC_K_ERR;
            NMC_CHAR_RST:  r_next.cmd.op = NMC_OP_RESET; // RULE6
            default:       r_next.cmd.op = NMC_OP_NONE;
          endcase
        end else if (r_reg.kw_ok && r_reg.len == NMC_KW_LEN && !r_reg.sp_seen) begin
          r_next.cmd.op = NMC_OP_ENTER; // RULE14
        end else if (r_reg.sp_seen && r_reg.digits != 2'h0 && !r_reg.id_bad
                     && r_reg.id <= NMC_ID_MAX) begin // RULE7 RULE8
          r_next.cmd.op = NMC_OP_ENTER_ID;
          r_next.cmd.id = r_reg.id[7:0];
        end
      end else if (!r_reg.sp_seen) begin
        if (r_reg.len == 4'h0) begin
          r_next.first = in_data;
        end
        if (in_data == NMC_CHAR_SP && r_reg.kw_ok && r_reg.len == NMC_KW_LEN) begin
          r_next.sp_seen = 1'b1; // RULE18
        end else begin
          if (r_reg.len >= NMC_KW_LEN || in_data != kw_char) begin
            r_next.kw_ok = 1'b0;
          end
          if (r_reg.len != NMC_LEN_SAT) begin
            r_next.len = 4'(r_reg.len + 4'h1);
          end
        end
      end else if (is_digit && r_reg.digits != NMC_ID_DIGITS) begin
        r_next.id = 10'(r_reg.id * 10'h00A + {2'h0, 8'(in_data - NMC_CHAR_DIG0)});
        r_next.digits = 2'(r_reg.digits + 2'h1);
      end else begin
        r_next.id_bad = 1'b1; // RULE8
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  a_cmd_after_cr: assert property (@(posedge clk) disable iff (rst) // RULE17
    cmd.valid |-> $past(in_valid) && $past(in_data) == NMC_CHAR_CR)
    else $error("command issued without carriage return");
  a_id_in_range: assert property (@(posedge clk) disable iff (rst) // RULE8
    (in_valid && in_data == NMC_CHAR_CR && r_reg.sp_seen && r_reg.id > NMC_ID_MAX)
    |=> cmd.op != NMC_OP_ENTER_ID)
    else $error("out of range identifier accepted");
endmodule
`default_nettype wire

// [nmc_handler.sv]
// normal-mode command handler: special datagram scheduling, reset and maintenance entry
//
// Functional notes
// (RULE1) five letter commands each request one special datagram
// (RULE2) special datagram takes next measurement datagram slot
// (RULE3) long special datagram may swallow several slots; here the next slot still opens while dg_busy is high
// (RULE4) external trigger slot carries pending special datagram
// (RULE5) clear error registers after error datagram sent
// (RULE6) reset letter command forces full unit reset
// (RULE7) optional unit identifier, values 0 to 255
// (RULE8) out of range identifier: ignore, no message
// (RULE9) finish current datagram before entering maintenance
// (RULE10) addressed entry delays response by one datagram
// (RULE11) after addressed entry, responses are undelayed
// (RULE12) other identifiers go silent during maintenance
// (RULE13) silent units resume without replying to exit
// (RULE14) entry without identifier always accepted
// (RULE15) host avoids unaddressed entry on shared line
// (RULE16) maintenance entry emits configuration listing
// (RULE17) carriage return executes every command
// (RULE18) space separates command from parameter
// (RULE19) host sends commands in upper case
// (RULE20) no echo, no error messages
// (RULE21) pending requests served in arrival order
`timescale 1ns/10ps
`default_nettype none
module nmc_handler
  import nmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  input  wire logic [7:0]  own_id,
  input  wire logic [15:0] dg_cycles,
  input  wire logic        dg_busy,
  input  wire logic        dg_done,
  input  wire logic        slot_take,
  input  wire logic        maint_exit,
  output logic             special_valid,
  output nmc_kind_e        special_kind,
  output logic             err_clear,
  output logic             unit_reset,
  output logic             maint_enter,
  output logic             listing_req,
  output logic             maint_active,
  output logic             tx_inhibit
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    nmc_mode_e  mode;
    logic       delay;
    logic [15:0] cnt;
    logic       pend_valid;
    nmc_kind_e  pend_kind;
    logic       err_inflight;
    logic       err_clear;
    logic       unit_reset;
    logic       maint_enter;
    logic       listing_req;
    logic       maint_active;
    logic       tx_inhibit;
  } nmc_main_s;

  nmc_main_s r_reg;
  nmc_main_s r_next;

  nmc_cmd_s                cmd;
  logic                    parse_valid;
  logic                    fifo_in_valid;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [NMC_KIND_W-1:0]   fifo_out_data;

  // ----------------------------------------------------------------
  // command parsing and request queue
  // ----------------------------------------------------------------
  // characters are only taken while the queue can absorb a request,
  // so a burst of letter commands stalls the receiver instead of dropping
  assign parse_valid = rx_valid && rx_ready;

  nmc_parser u_parser (
    .clk      (clk),
    .rst      (rst),
    .in_valid (parse_valid),
    .in_data  (rx_data),
    .cmd      (cmd)
  );

  assign fifo_in_valid  = cmd.valid && cmd.op == NMC_OP_SPECIAL && r_reg.mode == NMC_MD_NORMAL;
  assign fifo_out_ready = !r_reg.pend_valid;

  nmc_fifo #(
    .WIDTH (NMC_KIND_W),
    .DEPTH (NMC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (rx_ready),
    .in_data   (cmd.kind),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign special_valid = r_reg.pend_valid;
  assign special_kind  = r_reg.pend_kind;
  assign err_clear     = r_reg.err_clear;
  assign unit_reset    = r_reg.unit_reset;
  assign maint_enter   = r_reg.maint_enter;
  assign listing_req   = r_reg.listing_req;
  assign maint_active  = r_reg.maint_active;
  assign tx_inhibit    = r_reg.tx_inhibit;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.err_clear   = 1'b0;
    r_next.unit_reset  = 1'b0;
    r_next.maint_enter = 1'b0;
    r_next.listing_req = 1'b0;

    // the transmitter samples the head request in the slot it opens,
    // whether that slot is periodic or an external trigger
    if (r_reg.pend_valid && slot_take) begin // RULE2 RULE4
      r_next.pend_valid = 1'b0;
    end
    if (!r_reg.pend_valid && fifo_out_valid) begin // RULE21
      r_next.pend_valid = 1'b1;
      r_next.pend_kind  = nmc_kind_e'(fifo_out_data);
    end

    // the transmitter keeps dg_busy high for LEN cycles of a datagram, but its
    // next slot opens on cnt_reg, run and inhibit alone, even while a long datagram keeps dg_busy high
    if (dg_done && r_reg.err_inflight) begin // RULE3 RULE5
      r_next.err_clear    = 1'b1;
      r_next.err_inflight = 1'b0;
    end
    if (r_reg.pend_valid && slot_take && r_reg.pend_kind == NMC_K_ERR) begin
      r_next.err_inflight = 1'b1;
    end

    case (r_reg.mode)
      NMC_MD_NORMAL: begin
        if (cmd.valid) begin
          case (cmd.op)
            NMC_OP_RESET: begin
              r_next.unit_reset = 1'b1; // RULE6
            end
            NMC_OP_ENTER: begin
              r_next.mode       = NMC_MD_FINISH; // RULE14
              r_next.delay      = 1'b0;
              r_next.tx_inhibit = 1'b1;
            end
            NMC_OP_ENTER_ID: begin
              r_next.tx_inhibit = 1'b1;
              r_next.delay      = 1'b1;
              if (cmd.id == own_id) begin
                r_next.mode = NMC_MD_FINISH;
              end else begin
                r_next.mode = NMC_MD_MUTED; // RULE12
              end
            end
            default: begin
              r_next.mode = NMC_MD_NORMAL;
            end
          endcase
        end
      end
      NMC_MD_FINISH: begin
        // a datagram already on the line is allowed to end; inhibit only
        // stops the next one from starting
        if (!dg_busy) begin // RULE9
          if (r_reg.delay) begin
            r_next.mode = NMC_MD_DELAY; // RULE10
            r_next.cnt  = dg_cycles;
          end else begin
            r_next.mode         = NMC_MD_MAINT; // RULE11
            r_next.maint_enter  = 1'b1;
            r_next.listing_req  = 1'b1; // RULE16
            r_next.maint_active = 1'b1;
          end
        end
      end
      NMC_MD_DELAY: begin
        // one datagram time lets other units on the line fall silent
        if (r_reg.cnt == 16'h0000) begin // RULE10
          r_next.mode         = NMC_MD_MAINT;
          r_next.maint_enter  = 1'b1;
          r_next.listing_req  = 1'b1; // RULE16
          r_next.maint_active = 1'b1;
          r_next.delay        = 1'b0; // RULE11
        end else begin
          r_next.cnt = 16'(r_reg.cnt - 16'h0001);
        end
      end
      NMC_MD_MAINT: begin
        // the maintenance command set lives elsewhere; its responses
        // are immediate since the delay flag is already spent
        if (maint_exit) begin
          r_next.mode         = NMC_MD_NORMAL;
          r_next.maint_active = 1'b0;
          r_next.tx_inhibit   = 1'b0;
        end
      end
      NMC_MD_MUTED: begin
        // only the exit line is watched; nothing is said in return
        if (cmd.valid && cmd.op == NMC_OP_EXIT) begin // RULE13
          r_next.mode       = NMC_MD_NORMAL;
          r_next.tx_inhibit = 1'b0;
        end
      end
      default: begin
        r_next.mode = NMC_MD_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '{mode: NMC_MD_NORMAL, delay: 1'b0, cnt: '0, pend_valid: 1'b0,
                 pend_kind: NMC_K_PART, err_inflight: 1'b0, err_clear: 1'b0,
                 unit_reset: 1'b0, maint_enter: 1'b0, listing_req: 1'b0,
                 maint_active: 1'b0, tx_inhibit: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_err_taken;
    r_reg.pend_valid && slot_take && r_reg.pend_kind == NMC_K_ERR;
  endsequence

  sequence s_entry_done;
    r_reg.mode == NMC_MD_FINISH && !dg_busy;
  endsequence

  a_err_clear_done: assert property (@(posedge clk) disable iff (rst) // RULE5
    err_clear |-> $past(dg_done) && $past(r_reg.err_inflight))
    else $error("error registers cleared without finished error datagram");

  a_err_clear_follows: assert property (@(posedge clk) disable iff (rst) // RULE5
    (r_reg.err_inflight && dg_done) |=> err_clear)
    else $error("error datagram finished but registers not cleared");

  a_err_taken: assert property (@(posedge clk) disable iff (rst) // RULE5
    s_err_taken |=> r_reg.err_inflight)
    else $error("error datagram slot not tracked");

  a_reset_cmd: assert property (@(posedge clk) disable iff (rst) // RULE6
    (cmd.valid && cmd.op == NMC_OP_RESET && r_reg.mode == NMC_MD_NORMAL) |=> unit_reset)
    else $error("reset command did not reset the unit");

  a_reset_pulse: assert property (@(posedge clk) disable iff (rst) // RULE6
    unit_reset |=> !unit_reset)
    else $error("unit reset longer than one cycle");

  a_special_hold: assert property (@(posedge clk) disable iff (rst) // RULE2
    (special_valid && !slot_take) |=> special_valid && $stable(special_kind))
    else $error("pending special datagram lost before its slot");

  a_queue_load: assert property (@(posedge clk) disable iff (rst) // RULE21
    (!special_valid && fifo_out_valid) |=> special_valid && special_kind == $past(fifo_out_data))
    else $error("queued request not moved to the slot register");

  a_finish_wait: assert property (@(posedge clk) disable iff (rst) // RULE9
    (r_reg.mode == NMC_MD_FINISH && dg_busy) |=> !maint_enter && !maint_active)
    else $error("maintenance entered during a datagram");

  a_delay_entry: assert property (@(posedge clk) disable iff (rst) // RULE10
    (s_entry_done and r_reg.delay) |=> r_reg.mode == NMC_MD_DELAY && !maint_enter
    && r_reg.cnt == $past(dg_cycles))
    else $error("addressed entry not delayed by one datagram");

  a_delay_held: assert property (@(posedge clk) disable iff (rst) // RULE10
    r_reg.mode == NMC_MD_DELAY |-> tx_inhibit && !maint_active)
    else $error("unit talking during entry delay");

  a_direct_entry: assert property (@(posedge clk) disable iff (rst) // RULE11 RULE16
    (s_entry_done and !r_reg.delay) |=> maint_enter && listing_req && maint_active
    ##1 !maint_enter && !listing_req)
    else $error("unaddressed entry not immediate or without listing");

  a_muted_silent: assert property (@(posedge clk) disable iff (rst) // RULE12
    r_reg.mode == NMC_MD_MUTED |-> tx_inhibit && !maint_enter && !listing_req)
    else $error("muted unit is talking");

  a_exit_no_reply: assert property (@(posedge clk) disable iff (rst) // RULE13
    ($past(r_reg.mode) == NMC_MD_MUTED && r_reg.mode == NMC_MD_NORMAL)
    |-> !tx_inhibit && !listing_req ##1 !listing_req)
    else $error("muted unit replied to exit");

  a_bad_id_mute: assert property (@(posedge clk) disable iff (rst) // RULE12
    (cmd.valid && cmd.op == NMC_OP_ENTER_ID && cmd.id != own_id && r_reg.mode == NMC_MD_NORMAL)
    |=> r_reg.mode == NMC_MD_MUTED)
    else $error("unit addressed elsewhere did not go silent");
endmodule
`default_nettype wire

// [nmc_tx_model.sv]
// transmitter-side model: periodic datagram slots, busy span and done pulse
`timescale 1ns/10ps
`default_nettype none
module nmc_tx_model
  import nmc_pkg::*;
#(
  parameter int PERIOD = 20,
  parameter int LEN    = 8
) (
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      run,
  input  wire logic      inhibit,
  input  wire logic      special_valid,
  input  wire nmc_kind_e special_kind,
  output logic           slot_take,
  output logic           dg_busy,
  output logic           dg_done,
  output logic           got_spc,
  output nmc_kind_e      got_kind
);
  logic [7:0] cnt_reg;
  logic [7:0] busy_reg;

  assign dg_busy = busy_reg != 8'h00;

  // ----------------------------------------------------------------
  // slot timing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 8'h00;
      busy_reg  <= 8'h00;
      slot_take <= 1'b0;
      dg_done   <= 1'b0;
      got_spc   <= 1'b0;
      got_kind  <= NMC_K_PART;
    end else begin
      slot_take <= 1'b0;
      dg_done   <= 1'b0;
      got_spc   <= 1'b0;
      cnt_reg   <= (cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
      // a slot stands for a periodic sample or an external trigger alike
      if (cnt_reg == 8'h00 && run && !inhibit) begin
        slot_take <= 1'b1;
        busy_reg  <= 8'(LEN);
      end
      if (busy_reg != 8'h00) begin
        busy_reg <= busy_reg - 8'h01;
        dg_done  <= busy_reg == 8'h01;
      end
      // the slot carries the special datagram instead of measurement data
      if (slot_take) begin
        got_spc  <= special_valid;
        got_kind <= special_kind;
      end
    end
  end
endmodule
`default_nettype wire

// [test_nmc_handler.sv]
// self-checking testbench of the normal-mode command handler
`timescale 1ns/10ps
`default_nettype none
module test_nmc_handler;
  import nmc_pkg::*;
  localparam int DGC = 5;
  logic       clk, rst, rx_valid, rx_ready, dg_busy, dg_done, slot_take, maint_exit;
  logic       special_valid, err_clear, unit_reset, maint_enter, listing_req;
  logic       maint_active, tx_inhibit, run, got_spc, busy_d;
  logic [7:0] rx_data, own_id;
  nmc_kind_e  special_kind, got_kind;
  nmc_kind_e  got_q[$];
  int         n_mismatch, checks_done, n_enter, n_list, n_clr, n_rst, n_early, cyc;

  nmc_handler u_nmc_handler (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .own_id(own_id), .dg_cycles(16'(DGC)), .dg_busy(dg_busy),
    .dg_done(dg_done), .slot_take(slot_take), .maint_exit(maint_exit),
    .special_valid(special_valid), .special_kind(special_kind), .err_clear(err_clear),
    .unit_reset(unit_reset), .maint_enter(maint_enter), .listing_req(listing_req),
    .maint_active(maint_active), .tx_inhibit(tx_inhibit));
  nmc_tx_model u_nmc_tx_model (.clk(clk), .rst(rst), .run(run), .inhibit(tx_inhibit),
    .special_valid(special_valid), .special_kind(special_kind), .slot_take(slot_take),
    .dg_busy(dg_busy), .dg_done(dg_done), .got_spc(got_spc), .got_kind(got_kind));

  // ----------------------------------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (got_spc === 1'b1) got_q.push_back(got_kind);
    if (maint_enter === 1'b1) n_enter++;
    if (listing_req === 1'b1) n_list++;
    if (err_clear === 1'b1) n_clr++;
    if (unit_reset === 1'b1) n_rst++;
    if (maint_enter === 1'b1 && busy_d === 1'b1) n_early++;
    busy_d <= dg_busy;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // a character is held until the edge at which rx_ready is high
  task automatic send_byte(input logic [7:0] b);
    if (rx_valid !== 1'b1) @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= b;
    @(posedge clk iff rx_ready === 1'b1);
  endtask
  task automatic cr();
    send_byte(NMC_CHAR_CR);
    rx_valid <= 1'b0;
    @(posedge clk);
  endtask
  // upper-case keyword, optional space and decimal identifier
  task automatic kw_id(input string d);
    for (int i = 0; i < 11; i++) send_byte(NMC_KW_TEXT[87-8*i -: 8]);
    if (d.len() > 0) send_byte(NMC_CHAR_SP);
    foreach (d[i]) send_byte(d[i]);
    cr();
  endtask
  task automatic leave();
    @(posedge clk);
    maint_exit <= 1'b1;
    @(posedge clk);
    maint_exit <= 1'b0;
    waitn(2);
    chk("active_off", 16'h0, maint_active);
    chk("inhibit_off", 16'h0, tx_inhibit);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_special();
    nmc_kind_e  ek[5];
    logic [7:0] lt[5];
    int         c0;
    ek = '{NMC_K_PART, NMC_K_SERIAL, NMC_K_CONFIG, NMC_K_TRIM, NMC_K_ERR};
    lt = '{NMC_CHAR_PART, NMC_CHAR_SER, NMC_CHAR_CONF, NMC_CHAR_TRIM, NMC_CHAR_ERR};
    c0 = n_clr;
    got_q.delete();
    run <= 1'b1;
    foreach (lt[i]) begin
      send_byte(lt[i]);
      cr();
    end
    waitn(200);
    run <= 1'b0;
    waitn(30);
    chk("n_special", 16'h5, 16'(got_q.size()));
    foreach (ek[i]) chk("kind", 16'(ek[i]), 16'(got_q[i]));
    chk("err_clear", 16'h1, 16'(n_clr - c0));
    $display("done special requests");
  endtask
  task automatic t_queue();
    got_q.delete();
    repeat (8) begin
      send_byte(NMC_CHAR_CONF);
      cr();
    end
    waitn(4);
    chk("full", 16'h0, rx_ready);
    chk("pend", 16'h1, special_valid);
    run <= 1'b1;
    waitn(190);
    run <= 1'b0;
    waitn(30);
    chk("queued", 16'h8, 16'(got_q.size()));
    chk("ready_back", 16'h1, rx_ready);
    $display("done request queue");
  endtask
  task automatic t_rstcmd();
    int c0;
    c0 = n_rst;
    send_byte(8'h72);
    cr();
    send_byte(NMC_CHAR_RST);
    send_byte(NMC_CHAR_RST);
    cr();
    waitn(6);
    chk("rst_bad", 16'h0, 16'(n_rst - c0));
    send_byte(NMC_CHAR_RST);
    cr();
    waitn(6);
    chk("rst", 16'h1, 16'(n_rst - c0));
    $display("done reset command");
  endtask
  task automatic t_enter();
    int c0, c1, k;
    c0 = n_enter;
    c1 = n_list;
    run <= 1'b1;
    kw_id("");
    waitn(60);
    run <= 1'b0;
    chk("enter", 16'h1, 16'(n_enter - c0));
    chk("listing", 16'h1, 16'(n_list - c1));
    chk("early", 16'h0, 16'(n_early));
    chk("active", 16'h1, maint_active);
    leave();
    c0 = n_enter;
    kw_id("7");
    k = 0;
    while (n_enter == c0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk("delay", 16'h1, 16'(k > DGC + 1));
    chk("enter_id", 16'h1, 16'(n_enter - c0));
    leave();
    $display("done maintenance entry");
  endtask
  task automatic t_other();
    int c0;
    c0 = n_enter;
    kw_id("255");
    waitn(10);
    chk("muted", 16'h1, tx_inhibit);
    chk("muted_act", 16'h0, maint_active);
    send_byte(NMC_CHAR_PART);
    cr();
    waitn(8);
    chk("muted_drop", 16'h0, special_valid);
    send_byte(NMC_CHAR_EXIT);
    cr();
    waitn(4);
    chk("resumed", 16'h0, tx_inhibit);
    chk("no_reply", 16'h0, 16'(n_enter - c0));
    kw_id("256");
    waitn(10);
    chk("bad_id", 16'h0, tx_inhibit);
    chk("bad_enter", 16'h0, 16'(n_enter - c0));
    $display("done other identifiers");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    own_id = 8'h07;
    maint_exit = 1'b0;
    run = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    waitn(1);
    chk("ready", 16'h1, rx_ready);
    chk("idle", 16'h0, {special_valid, err_clear, unit_reset, maint_enter, maint_active, tx_inhibit});
    $display("done reset state");
    t_special();
    t_queue();
    t_rstcmd();
    t_enter();
    t_other();
    end_of_test();
  end
endmodule
`default_nettype wire
